// ---- rtl/ibd_params.svh ----
// constants of the brake and dead-time block
`ifndef IBD_PARAMS_SVH
`define IBD_PARAMS_SVH

`define IBD_CLK_MHZ 25
`define IBD_DT_MIN_NS 100
`define IBD_DT_MIN_CYC ((`IBD_DT_MIN_NS * `IBD_CLK_MHZ + 999) / 1000)

`define IBD_ADDR_CTRL 8'h00
`define IBD_ADDR_DEADTIME 8'h04
`define IBD_ADDR_SLEW 8'h08
`define IBD_ADDR_STATUS 8'h0c
`define IBD_ADDR_IRQ_STATUS 8'h10
`define IBD_ADDR_IRQ_MASK 8'h14

`define IBD_CTRL_MODE_LSB 0
`define IBD_CTRL_OCP_EN 2
`define IBD_CTRL_WDT_EN 3
`define IBD_DEADTIME_RISING_LSB 0
`define IBD_DEADTIME_FALLING_LSB 8

`define IBD_IRQ_BRAKE_START 0
`define IBD_IRQ_BRAKE_END 1
`define IBD_IRQ_OCP 2
`define IBD_IRQ_WDT 3

`define IBD_RST_MODE 2'h0
`define IBD_RST_DT 8'h0a
`define IBD_RST_SLEW 4'h0

`endif

// ---- rtl/ibd_pkg.sv ----
// types of the brake and dead-time block
`include "ibd_params.svh"
package ibd_pkg;
  typedef enum logic [1:0] {
    IBD_BRK_LOW,
    IBD_BRK_HIGH,
    IBD_BRK_ALT,
    IBD_BRK_HIZ
  } ibd_mode_t;

  typedef struct packed {
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic brk_prev;
    logic ocp_prev;
    logic wdt_prev;
    logic alt_high;
    logic brake_side;
    logic [2:0] hi;
    logic [2:0] lo;
    logic [2:0] hiz;
    logic [2:0][7:0] cnt;
    ibd_mode_t mode;
    logic ocp_en;
    logic wdt_en;
    logic [7:0] deadtime_rising;
    logic [7:0] deadtime_falling;
    logic [3:0] slew;
    logic [3:0] slew_act;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic [31:0] rdata;
  } ibd_state_t;
endpackage

// ---- rtl/ibd_core.sv ----
// brake sequencing and dead-time insertion for three inverter phases
`timescale 1ns/1ns
// Notes on behaviour
// - braking can be entered from any pwm input pattern.
// - brake pin low, or enabled overcurrent or watchdog fault, starts braking.
// - controller holds brake pin high normally; low starts braking at once.
// - brake ignored during supply undervoltage; pin high resumes pwm propagation.
// - mode selects low-side, high-side, alternating or high-impedance braking.
// - low-side braking turns all low gates on, all high gates off.
// - high-side braking turns all high gates on, all low gates off.
// - alternating braking flips side on each new brake event.
// - high-impedance braking releases all six gate outputs.
// - conflicting switch turns off at once; braking switch waits dead time.
// - brake settings may change at run time and apply without restart.
// - internal gpio brake and brake pin combine into one brake input.
// - dead time between high and low gate of each phase.
// - rising node edge uses rise dead time, falling uses fall dead time.
// - a fixed minimum dead time always applies.
// - slew and dead-time changes apply only at switching edges.
module ibd_core
  import ibd_pkg::*;
#(
  parameter int DT_W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic brake_request_n,
  input wire logic internal_brake_gpio,
  input wire logic overcurrent_fault,
  input wire logic watchdog_fault,
  input wire logic digital_supply_undervoltage,
  input wire logic [2:0] pwm_high_in,
  input wire logic [2:0] pwm_low_in,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic [2:0] gate_high_out,
  output logic [2:0] gate_low_out,
  output logic [2:0] gate_high_oe,
  output logic [2:0] gate_low_oe,
  output logic [3:0] slew_setting,
  output logic brake_active
);

  localparam logic [DT_W-1:0] DT_MIN = DT_W'(`IBD_DT_MIN_CYC);

  ibd_state_t s;
  ibd_state_t next_s;

  // **********************************
  // derived signals
  // **********************************
  logic brk_n_s;
  logic ocp_s;
  logic wdt_s;
  logic uv_s;
  logic [2:0] ph_s;
  logic [2:0] pl_s;
  logic trig;
  logic brk_now;
  logic brk_start;
  logic brk_end;
  logic side_high;
  logic [2:0] th;
  logic [2:0] tl;
  logic [2:0] thz;
  logic sw_edge;

  assign brk_n_s = s.sync2[0];
  assign ocp_s = s.sync2[1];
  assign wdt_s = s.sync2[2];
  assign uv_s = s.sync2[3];
  assign ph_s = s.sync2[6:4];
  assign pl_s = s.sync2[9:7];

  function automatic logic [DT_W-1:0] eff_dt(input logic [7:0] dt);
    logic [DT_W-1:0] v;
    v = DT_W'(dt);
    eff_dt = (v < DT_MIN) ? DT_MIN : v;
  endfunction

  // **********************************
  // next state
  // **********************************
  always_comb begin
    next_s = s;
    // wired-and of both brake sources, then two flops
    next_s.sync1 = {pwm_low_in, pwm_high_in, digital_supply_undervoltage,
                    watchdog_fault, overcurrent_fault,
                    brake_request_n & internal_brake_gpio};
    next_s.sync2 = s.sync1;

    // brake trigger, ignored while the digital supply is low
    trig = !brk_n_s || (s.ocp_en && ocp_s) || (s.wdt_en && wdt_s);
    brk_now = !uv_s && trig;
    brk_start = brk_now && !s.brk_prev;
    brk_end = !brk_now && s.brk_prev;
    next_s.brk_prev = brk_now;
    next_s.ocp_prev = ocp_s;
    next_s.wdt_prev = wdt_s;

    // side memory: in alternating mode each new event takes the other side
    if (brk_start) begin
      if (s.mode == IBD_BRK_ALT) begin
        next_s.brake_side = s.alt_high;
        next_s.alt_high = !s.alt_high;
      end else begin
        next_s.brake_side = (s.mode == IBD_BRK_HIGH);
      end
    end

    // mode read live so run-time changes act at once
    case (s.mode)
      IBD_BRK_LOW: side_high = 1'b0;
      IBD_BRK_HIGH: side_high = 1'b1;
      IBD_BRK_ALT: side_high = brk_start ? s.alt_high : s.brake_side;
      default: side_high = 1'b0;
    endcase

    // targets: brake pattern overrides any pwm pattern
    if (brk_now) begin
      th = side_high ? 3'h7 : 3'h0;
      tl = side_high ? 3'h0 : 3'h7;
      thz = (s.mode == IBD_BRK_HIZ) ? 3'h7 : 3'h0;
      if (s.mode == IBD_BRK_HIZ) begin
        th = 3'h0;
        tl = 3'h0;
      end
    end else begin
      // both inputs high is not a legal drive; both stay off
      th = ph_s & ~pl_s;
      tl = pl_s & ~ph_s;
      thz = 3'h0;
    end
    next_s.hiz = thz;

    // per-phase dead time sequencing
    sw_edge = 1'b0;
    for (int i = 0; i < 3; i++) begin
      next_s.hi[i] = s.hi[i] & th[i];
      next_s.lo[i] = s.lo[i] & tl[i];
      if (s.cnt[i] != '0) begin
        next_s.cnt[i] = s.cnt[i] - 8'h01;
      end
      // dead time sampled only when a switch turns off
      if (s.lo[i] && !tl[i]) begin
        next_s.cnt[i] = eff_dt(s.deadtime_rising);
        sw_edge = 1'b1;
      end else if (s.hi[i] && !th[i]) begin
        next_s.cnt[i] = eff_dt(s.deadtime_falling);
        sw_edge = 1'b1;
      end
      if (s.cnt[i] == '0 && !s.hi[i] && !s.lo[i]) begin
        next_s.hi[i] = th[i];
        next_s.lo[i] = tl[i];
      end
    end
    // slew code follows the switching edges only
    if (sw_edge) begin
      next_s.slew_act = s.slew;
    end

    // sticky events; read clears, but a new event wins
    next_s.rdata = 32'h0;
    if (reg_read) begin
      case (reg_addr)
        `IBD_ADDR_CTRL: next_s.rdata = {28'h0, s.wdt_en, s.ocp_en, s.mode};
        `IBD_ADDR_DEADTIME: next_s.rdata = {16'h0, s.deadtime_falling, s.deadtime_rising};
        `IBD_ADDR_SLEW: next_s.rdata = {28'h0, s.slew};
        `IBD_ADDR_STATUS: next_s.rdata = {20'h0, s.hiz, s.lo, s.hi,
                                          s.alt_high, uv_s, s.brk_prev};
        `IBD_ADDR_IRQ_STATUS: begin
          next_s.rdata = {28'h0, s.irq_st};
          next_s.irq_st = 4'h0;
        end
        `IBD_ADDR_IRQ_MASK: next_s.rdata = {28'h0, s.irq_mask};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (brk_start) next_s.irq_st[`IBD_IRQ_BRAKE_START] = 1'b1;
    if (brk_end) next_s.irq_st[`IBD_IRQ_BRAKE_END] = 1'b1;
    if (s.ocp_en && ocp_s && !s.ocp_prev) next_s.irq_st[`IBD_IRQ_OCP] = 1'b1;
    if (s.wdt_en && wdt_s && !s.wdt_prev) next_s.irq_st[`IBD_IRQ_WDT] = 1'b1;

    // register writes
    if (reg_write) begin
      case (reg_addr)
        `IBD_ADDR_CTRL: begin
          next_s.mode = ibd_mode_t'(reg_wdata[`IBD_CTRL_MODE_LSB +: 2]);
          next_s.ocp_en = reg_wdata[`IBD_CTRL_OCP_EN];
          next_s.wdt_en = reg_wdata[`IBD_CTRL_WDT_EN];
        end
        `IBD_ADDR_DEADTIME: begin
          next_s.deadtime_rising = reg_wdata[`IBD_DEADTIME_RISING_LSB +: 8];
          next_s.deadtime_falling = reg_wdata[`IBD_DEADTIME_FALLING_LSB +: 8];
        end
        `IBD_ADDR_SLEW: next_s.slew = reg_wdata[3:0];
        `IBD_ADDR_IRQ_MASK: next_s.irq_mask = reg_wdata[3:0];
        default: next_s.slew = next_s.slew;
      endcase
    end
  end

  // **********************************
  // state register
  // **********************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
      // brake pin level idles high so no false brake at release
      s.sync1 <= 10'h001;
      s.sync2 <= 10'h001;
      s.alt_high <= 1'b0;
      s.mode <= ibd_mode_t'(`IBD_RST_MODE);
      s.deadtime_rising <= `IBD_RST_DT;
      s.deadtime_falling <= `IBD_RST_DT;
      s.slew <= `IBD_RST_SLEW;
      s.slew_act <= `IBD_RST_SLEW;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // **********************************
  // outputs
  // **********************************
  // a slow read answer is harmless: the value is one cycle old
  assign reg_rdata = s.rdata;
  assign irq = |(s.irq_st & s.irq_mask);
  assign gate_high_out = s.hi;
  assign gate_low_out = s.lo;
  assign gate_high_oe = ~s.hiz;
  assign gate_low_oe = ~s.hiz;
  assign slew_setting = s.slew_act;
  assign brake_active = s.brk_prev;

endmodule

// ---- sim/ibd_core_sva.sv ----
// assertion checker for the brake and dead-time block
`timescale 1ns/1ns
module ibd_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic brake_request_n,
  input wire logic internal_brake_gpio,
  input wire logic overcurrent_fault,
  input wire logic digital_supply_undervoltage,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  input wire logic [2:0] gate_high_out,
  input wire logic [2:0] gate_low_out,
  input wire logic [2:0] gate_high_oe,
  input wire logic [2:0] gate_low_oe,
  input wire logic brake_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_no_overlap: assert property ((gate_high_out & gate_low_out) == 3'h0)
    else $error("high and low gate on together");
  a_brake_start: assert property ($fell(brake_request_n) && internal_brake_gpio
    && !digital_supply_undervoltage |-> ##[1:4] brake_active)
    else $error("brake pin low not acted on");
  a_uv_block: assert property (digital_supply_undervoltage [*4] |-> !$rose(brake_active))
    else $error("brake started during undervoltage");
  a_hiz_all: assert property ((gate_high_oe != 3'h7 || gate_low_oe != 3'h7)
    |-> gate_high_oe == 3'h0 && gate_low_oe == 3'h0 && (gate_high_out | gate_low_out) == 3'h0)
    else $error("partial high impedance state");
  // bench programs fall 5 and rise 2; rise must still wait the 3-cycle minimum
  a_deadtime_falling: assert property ($fell(gate_high_out[0]) |-> !gate_low_out[0] [*6])
    else $error("low gate on inside fall dead time");
  a_deadtime_rising: assert property ($fell(gate_low_out[1]) |-> !gate_high_out[1] [*4])
    else $error("high gate on inside minimum dead time");
  a_brake_pattern: assert property ($rose(brake_active) |-> ##[1:40]
    (gate_low_out == 3'h7 && gate_high_out == 3'h0) || gate_low_oe == 3'h0
    || (gate_high_out == 3'h7 && gate_low_out == 3'h0))
    else $error("brake pattern not reached");
  a_brake_end: assert property ($rose(brake_request_n) && internal_brake_gpio
    && !overcurrent_fault |-> ##[1:4] !brake_active)
    else $error("brake did not end");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside read answer");
  c_brake: cover property ($rose(brake_active));
  c_hiz: cover property (gate_low_oe == 3'h0);
  c_irq: cover property ($rose(irq));
endmodule
bind ibd_core ibd_sva u_sva (.*);

// ---- sim/ibd_mcu_model.sv ----
// controller side: complementary pwm demand and brake pin
`timescale 1ns/1ns
module ibd_mcu_model #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic brake_cmd,
  output logic brake_request_n,
  output logic [2:0] pwm_high_in,
  output logic [2:0] pwm_low_in
);
  int cnt = 0;
  logic ph = 1'h0;
  // pin stays high unless a brake is wanted
  assign brake_request_n = !brake_cmd;
  // no dead time here: the block must insert it
  assign pwm_high_in = {3{ph}};
  assign pwm_low_in = {3{!ph}};
  always @(posedge clk) begin
    cnt <= (!reset_n || cnt == HALF - 1) ? 0 : cnt + 1;
    ph <= reset_n && (ph ^ (cnt == HALF - 1));
  end
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the brake and dead-time block
`timescale 1ns/1ns
`include "ibd_params.svh"
module tb_top;
  logic clk = 1'h0, reset_n = 1'h0, clk_en = 1'h1, internal_brake_gpio = 1'h1, brk = 1'h0;
  logic overcurrent_fault = 1'h0, watchdog_fault = 1'h0, digital_supply_undervoltage = 1'h0;
  logic reg_write = 1'h0, reg_read = 1'h0, brake_request_n, irq, brake_active;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [2:0] pwm_high_in, pwm_low_in, gate_high_out, gate_low_out, gate_high_oe, gate_low_oe;
  logic [3:0] slew_setting;
  logic [1:0] md [5] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h3};
  logic [11:0] ex [5] = '{12'hfc7, 12'hff8, 12'hfc7, 12'hff8, 12'h000};
  int err_count = 0, samples_checked = 0;
  ibd_mcu_model #(.HALF(8)) u_mcu (.clk(clk), .reset_n(reset_n), .brake_cmd(brk),
    .brake_request_n(brake_request_n), .pwm_high_in(pwm_high_in), .pwm_low_in(pwm_low_in));
  ibd_core DUT (.*);
  initial begin
    forever #20 clk = !clk;
  end
  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_write <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic print_verdict();
    $display("checked=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wt(input logic v);
    for (int i = 0; i < 40 && brake_active !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(brake_active, v);
    if (brake_active !== v) print_verdict();
  endtask
  initial begin
    #800000;
    err_count++;
    print_verdict();
  end
  initial begin
    cyc(3);
    #1 chk({gate_high_oe, gate_low_oe, gate_high_out, gate_low_out, brake_active}, 32'h1f80);
    @(posedge clk);
    reset_n <= 1'h1;
    wr(`IBD_ADDR_DEADTIME, 32'h0502);
    wr(`IBD_ADDR_IRQ_MASK, 32'h1);
    rd(8'h3c);
    chk(d, 32'h0);
    // hiz stands last, as a controller would pick after a shorted switch
    for (int i = 0; i < 5; i++) begin
      wr(`IBD_ADDR_CTRL, {30'h0, md[i]});
      cyc(20);
      brk <= 1'h1;
      wt(1'h1);
      cyc(12);
      #1 chk({gate_high_oe, gate_low_oe, gate_high_out, gate_low_out}, ex[i]);
      cyc(1);
      brk <= 1'h0;
      wt(1'h0);
      $display("brake mode %0d done", md[i]);
    end
    rd(`IBD_ADDR_CTRL);
    chk(d, 32'h3);
    chk(irq, 1'h1);
    rd(`IBD_ADDR_IRQ_STATUS);
    chk(d[0], 1'h1);
    cyc(2);
    #1 chk(irq, 1'h0);
    wr(`IBD_ADDR_IRQ_MASK, 32'h0);
    internal_brake_gpio <= 1'h0;
    wt(1'h1);
    chk(irq, 1'h0);
    cyc(12);
    internal_brake_gpio <= 1'h1;
    wt(1'h0);
    $display("irq and gpio brake done");
    digital_supply_undervoltage <= 1'h1;
    cyc(4);
    brk <= 1'h1;
    cyc(10);
    #1 chk(brake_active, 1'h0);
    cyc(1);
    brk <= 1'h0;
    digital_supply_undervoltage <= 1'h0;
    wr(`IBD_ADDR_SLEW, 32'h5);
    cyc(40);
    #1 chk(slew_setting, 4'h5);
    $display("undervoltage and slew done");
    wr(`IBD_ADDR_CTRL, 32'h4);
    overcurrent_fault <= 1'h1;
    wt(1'h1);
    cyc(12);
    #1 chk(gate_low_out, 3'h7);
    $display("overcurrent brake done");
    overcurrent_fault <= 1'h0;
    wr(`IBD_ADDR_CTRL, 32'h8);
    wt(1'h0);
    watchdog_fault <= 1'h1;
    wt(1'h1);
    // clock enable low must hold the brake although the fault is gone
    clk_en <= 1'h0;
    watchdog_fault <= 1'h0;
    cyc(8);
    #1 chk(brake_active, 1'h1);
    clk_en <= 1'h1;
    wt(1'h0);
    rd(`IBD_ADDR_IRQ_STATUS);
    chk(d, 32'hf);
    $display("watchdog brake and clock enable done");
    print_verdict();
  end
endmodule
